/* File: logic/pmu_i2c_regs.svh */
// constants of the register-access serial port: bus codes, widths, timing
// assumes inclusion from the package and the port module only
`ifndef PMU_I2C_REGS_SVH
`define PMU_I2C_REGS_SVH

// ------------------------------------------------------------------
// bus address bytes
// ------------------------------------------------------------------
`define WRITE_ADDRESS_BYTE 8'h82
`define READ_ADDRESS_BYTE 8'h83

// ------------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------------
`define PTR_W 8
`define DATA_W 8
`define PTR_RESET 8'h00
`define WR_FIFO_DEPTH 2

// ------------------------------------------------------------------
// timing: fastest serial clock and its length in system cycles
// ------------------------------------------------------------------
`define MCLK_PERIOD_PS 5000
`define SCL_MIN_PERIOD_PS 2500000
`define SCL_MIN_PERIOD_CYC (`SCL_MIN_PERIOD_PS / `MCLK_PERIOD_PS)

`endif

/* File: logic/pmu_i2c_pkg.sv */
// types shared by the register-access serial port
// assumes the constants header is on the include path
`include "pmu_i2c_regs.svh"
`default_nettype none

package pmu_i2c_pkg;

  // ------------------------------------------------------------------
  // port state, gray along receive path
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    st_idle = 4'h0,
    st_dev_addr = 4'h1,
    st_dev_ack = 4'h3,
    st_pointer_byte = 4'h2,
    st_pointer_ack = 4'h6,
    st_wr_data = 4'h7,
    st_wr_ack = 4'h5,
    st_rd_data = 4'h4,
    st_rd_ack = 4'hC,
    st_wait = 4'hD
  } port_state_e;

  // one register write towards the register space
  typedef struct packed {
    logic [`PTR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } reg_write_s;

endpackage : pmu_i2c_pkg

`default_nettype wire

/* File: logic/pmu_i2c_register_slave.sv */
// fixed-address serial slave giving a bus master byte access to registers
// assumes register space reads combinationally at rd_addr on mclk, and
// drains writes through wr_valid/wr_ready; serial pins are asynchronous
//
// Operation
// - Only the write address byte 82h and read address byte 83h are answered, others ignored.
// - Serial clocks up to 400 kHz are served; the master clocks no faster.
// - A write carries the write address byte then a pointer byte loaded into the pointer.
// - Any number of data bytes follow, each stored at the pointer unless the write buffer is full; the pointer advances either way.
// - The pointer advances in the acknowledge phase of every data byte, read or write.
// - After acknowledging the read address byte the device sends bytes from the pointer on.
// - A random read returns the register chosen by the earlier pointer byte.
// - A master ack asks for another byte and the device keeps sending without limit.
// - On the master not-acknowledge the device releases data and stops sending.
// - A read address byte with no pointer byte reads from the pointer left before.
`include "pmu_i2c_regs.svh"
`default_nettype none

module pmu_i2c_register_slave #(
  parameter int FIFO_DEPTH = `WR_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // register read port
  output logic [`PTR_W-1:0] rd_addr,
  input wire logic [`DATA_W-1:0] rd_data,
  // register write stream
  output logic wr_valid,
  input wire logic wr_ready,
  output pmu_i2c_pkg::reg_write_s wr_word
);

  localparam int AW = (FIFO_DEPTH > 2) ? $clog2(FIFO_DEPTH) : 1;
  localparam int SCL_HALF_CYC = `SCL_MIN_PERIOD_CYC / 2;

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  generate
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two, at least 2");
    end
    if (SCL_HALF_CYC < 8)
    begin : g_bad_rate
      $error("system clock too slow for the serial clock");
    end
  endgenerate

  // ------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------------
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= sda_i;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s2_ff & ~scl_d_ff;
  assign scl_fall = ~scl_s2_ff & scl_d_ff;
  // data moving while clock held high
  assign start_det = scl_s2_ff & scl_d_ff & ~sda_s2_ff & sda_d_ff;
  assign stop_det = scl_s2_ff & scl_d_ff & sda_s2_ff & ~sda_d_ff;

  // ------------------------------------------------------------------
  // write buffer
  // ------------------------------------------------------------------
  pmu_i2c_pkg::reg_write_s mem_ff [FIFO_DEPTH];
  logic [AW-1:0] wp_ff, rp_ff;
  logic [AW:0] cnt_ff;
  logic fifo_full, push, pop;
  pmu_i2c_pkg::reg_write_s push_word;

  assign fifo_full = (cnt_ff == (AW+1)'(FIFO_DEPTH));
  assign wr_valid = (cnt_ff != '0);
  assign pop = wr_valid & wr_ready;
  assign wr_word = mem_ff[rp_ff];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++)
      begin
        mem_ff[i] <= '0;
      end
    end
    else
    begin
      if (push)
      begin
        mem_ff[wp_ff] <= push_word;
        wp_ff <= wp_ff + AW'(1);
      end
      if (pop)
      begin
        rp_ff <= rp_ff + AW'(1);
      end
      if (push && !pop)
      begin
        cnt_ff <= cnt_ff + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        cnt_ff <= cnt_ff - (AW+1)'(1);
      end
    end
  end

  // ------------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------------
  pmu_i2c_pkg::port_state_e state_ff;
  logic [2:0] bit_cnt_ff;
  logic byte_done_ff;
  logic [7:0] rx_sr_ff;
  logic [7:0] tx_sr_ff;
  logic oe_ff;
  logic [`PTR_W-1:0] ptr_ff;
  logic master_ack_ff;
  logic dev_read_ff;
  logic push_ff;
  pmu_i2c_pkg::reg_write_s push_word_ff;

  assign push = push_ff;
  assign push_word = push_word_ff;
  assign sda_o = 1'b0;
  assign sda_oe = oe_ff;
  assign rd_addr = ptr_ff;

  logic rx_state;
  assign rx_state = (state_ff == pmu_i2c_pkg::st_dev_addr)
                 || (state_ff == pmu_i2c_pkg::st_pointer_byte)
                 || (state_ff == pmu_i2c_pkg::st_wr_data);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= pmu_i2c_pkg::st_idle;
      bit_cnt_ff <= 3'h0;
      byte_done_ff <= 1'b0;
      rx_sr_ff <= 8'h00;
      tx_sr_ff <= 8'h00;
      oe_ff <= 1'b0;
      ptr_ff <= `PTR_RESET;
      master_ack_ff <= 1'b0;
      dev_read_ff <= 1'b0;
      push_ff <= 1'b0;
      push_word_ff <= '0;
    end
    else
    begin
      push_ff <= 1'b0;
      if (start_det)
      begin
        // fresh or repeated start; pointer kept for current-address read
        state_ff <= pmu_i2c_pkg::st_dev_addr;
        bit_cnt_ff <= 3'h0;
        byte_done_ff <= 1'b0;
        oe_ff <= 1'b0;
      end
      else if (stop_det)
      begin
        state_ff <= pmu_i2c_pkg::st_idle;
        oe_ff <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (rx_state)
        begin
          rx_sr_ff <= {rx_sr_ff[6:0], sda_s2_ff};
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          byte_done_ff <= (bit_cnt_ff == 3'h7);
        end
        else if (state_ff == pmu_i2c_pkg::st_rd_data)
        begin
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
          byte_done_ff <= (bit_cnt_ff == 3'h7);
        end
        else if (state_ff == pmu_i2c_pkg::st_rd_ack)
        begin
          master_ack_ff <= ~sda_s2_ff;
        end
      end
      else if (scl_fall)
      begin
        unique case (state_ff)
          pmu_i2c_pkg::st_dev_addr:
          begin
            if (byte_done_ff)
            begin
              byte_done_ff <= 1'b0;
              if (rx_sr_ff == `WRITE_ADDRESS_BYTE || rx_sr_ff == `READ_ADDRESS_BYTE)
              begin
                oe_ff <= 1'b1;
                dev_read_ff <= rx_sr_ff[0];
                state_ff <= pmu_i2c_pkg::st_dev_ack;
              end
              else
              begin
                state_ff <= pmu_i2c_pkg::st_wait;
              end
            end
          end
          pmu_i2c_pkg::st_dev_ack:
          begin
            bit_cnt_ff <= 3'h0;
            if (dev_read_ff)
            begin
              // first byte straight after the ack, from the current pointer
              tx_sr_ff <= rd_data;
              oe_ff <= ~rd_data[7];
              state_ff <= pmu_i2c_pkg::st_rd_data;
            end
            else
            begin
              oe_ff <= 1'b0;
              state_ff <= pmu_i2c_pkg::st_pointer_byte;
            end
          end
          pmu_i2c_pkg::st_pointer_byte:
          begin
            if (byte_done_ff)
            begin
              byte_done_ff <= 1'b0;
              ptr_ff <= rx_sr_ff;
              oe_ff <= 1'b1;
              state_ff <= pmu_i2c_pkg::st_pointer_ack;
            end
          end
          pmu_i2c_pkg::st_pointer_ack, pmu_i2c_pkg::st_wr_ack:
          begin
            oe_ff <= 1'b0;
            bit_cnt_ff <= 3'h0;
            state_ff <= pmu_i2c_pkg::st_wr_data;
          end
          pmu_i2c_pkg::st_wr_data:
          begin
            if (byte_done_ff)
            begin
              byte_done_ff <= 1'b0;
              // a full buffer refuses the byte with not-acknowledge
              push_ff <= ~fifo_full;
              push_word_ff <= '{addr: ptr_ff, data: rx_sr_ff};
              oe_ff <= ~fifo_full;
              ptr_ff <= ptr_ff + `PTR_W'(1);
              state_ff <= pmu_i2c_pkg::st_wr_ack;
            end
          end
          pmu_i2c_pkg::st_rd_data:
          begin
            if (byte_done_ff)
            begin
              byte_done_ff <= 1'b0;
              oe_ff <= 1'b0;
              ptr_ff <= ptr_ff + `PTR_W'(1);
              state_ff <= pmu_i2c_pkg::st_rd_ack;
            end
            else
            begin
              tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
              oe_ff <= ~tx_sr_ff[6];
            end
          end
          pmu_i2c_pkg::st_rd_ack:
          begin
            bit_cnt_ff <= 3'h0;
            if (master_ack_ff)
            begin
              tx_sr_ff <= rd_data;
              oe_ff <= ~rd_data[7];
              state_ff <= pmu_i2c_pkg::st_rd_data;
            end
            else
            begin
              oe_ff <= 1'b0;
              state_ff <= pmu_i2c_pkg::st_wait;
            end
          end
          pmu_i2c_pkg::st_idle, pmu_i2c_pkg::st_wait:
          begin
            oe_ff <= 1'b0;
          end
          default:
          begin
            oe_ff <= 1'b0;
            state_ff <= pmu_i2c_pkg::st_idle;
          end
        endcase
      end
    end
  end

endmodule // pmu_i2c_register_slave

`default_nettype wire

/* File: dv/pmu_i2c_asserts.sv */
// checker on the serial slave ports
// assumes a bind onto the slave module
`default_nettype none
module pmu_i2c_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // register side
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire pmu_i2c_pkg::reg_write_s wr_word
);
  logic [1:0] age_ff;
  // cycles since reset release, saturating
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      age_ff <= 2'h0;
    else if (age_ff != 2'h3)
      age_ff <= age_ff + 2'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  chk_drain_only: assert property (sda_o == 1'b0)
    else $error("sda output not low");
  chk_reset_idle: assert property (age_ff < 2'h2 |-> !sda_oe && !wr_valid && rd_addr == 8'h00)
    else $error("outputs not idle after reset");
  chk_oe_after_fall: assert property ($changed(sda_oe) |-> !$past(scl_i, 2) && $past(scl_i, 6))
    else $error("data drive changed away from a clock fall");
  chk_ptr_after_fall: assert property ($changed(rd_addr) |-> !$past(scl_i, 2) && $past(scl_i, 6))
    else $error("pointer moved away from a clock fall");
  chk_push_addr: assert property ($rose(wr_valid) |-> rd_addr == wr_word.addr + 8'h01)
    else $error("pushed word not at pointer before step");
  chk_stall_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
    else $error("buffered word lost in stall");
  chk_ack_stands: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("low drive shorter than a clock low phase");
  chk_pop_only: assert property ($fell(wr_valid) |-> $past(wr_ready))
    else $error("buffer emptied without a pop");
  cover property (wr_valid && !wr_ready ##1 wr_valid && wr_ready);
  cover property ($rose(sda_oe));
  cover property ($past(rd_addr) == 8'hFF && rd_addr == 8'h00);
endmodule // pmu_i2c_asserts
bind pmu_i2c_register_slave pmu_i2c_asserts u_chk (.mclk(mclk), .arst_n(arst_n), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .rd_addr(rd_addr), .rd_data(rd_data),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word));
`default_nettype wire

/* File: dv/i2c_master_model.sv */
// serial bus master driving the clock and pulling the data line
// assumes a pull-up resolves the data wire outside
`default_nettype none
module i2c_master_model (
  // bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // data falls while clock high; also serves as repeated start
  task automatic start();
    sda_pull = 1'b0;
    #20 scl = 1'b1;
    #20 sda_pull = 1'b1;
    #20 scl = 1'b0;
    #20;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    #20 scl = 1'b1;
    #20 sda_pull = 1'b0;
    #40;
  endtask
  // nine bits msb first, 80 ns each, sampled mid high
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_pull = !tx[i];
      #20 scl = 1'b1;
      #20 rx[i] = sda;
      #20 scl = 1'b0;
      #20;
    end
  endtask
endmodule // i2c_master_model
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the register-access serial slave
// assumes the slave, its package and the master model are compiled
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic wr_ready = 1'b1;
  logic scl, pull, sda_o, sda_oe, wr_valid;
  logic [7:0] rd_addr, rd_data;
  logic [8:0] rx;
  wire logic sda;
  pmu_i2c_pkg::reg_write_s wr_word;
  logic [7:0] mem [0:255];
  logic [7:0] ref_mem [0:255];
  logic [15:0] rows [0:3] = '{16'h10AB, 16'h3C5A, 16'h8000, 16'hC7FF};
  int fail_count = 0;
  int samples_checked = 0;
  always #2.5 mclk = ~mclk;
  assign sda = ~(pull | (sda_oe & ~sda_o));
  assign rd_data = mem[rd_addr];
  always @(posedge mclk)
    if (wr_valid && wr_ready)
      mem[wr_word.addr] <= wr_word.data;
  pmu_i2c_register_slave u_dut (.mclk(mclk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .rd_addr(rd_addr), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word));
  i2c_master_model u_mst (.scl(scl), .sda_pull(pull), .sda(sda));
  task automatic check8(input string what, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check1(input string what, input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  // send a byte, ack expected means wire low in ninth bit
  task automatic put(input logic [7:0] b, input logic ack);
    u_mst.xfer({b, 1'b1}, rx);
    check1("ack", rx[0], !ack);
  endtask
  task automatic get(input logic [7:0] exp, input logic last);
    u_mst.xfer({8'hFF, last}, rx);
    check8("read", rx[8:1], exp);
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 8'(i) ^ 8'h5A;
      ref_mem[i] = 8'(i) ^ 8'h5A;
    end
    repeat (8) @(negedge mclk);
    check8("reset ptr", rd_addr, 8'h00);
    check1("reset drive", sda_oe, 1'b0);
    arst_n = 1'b1;
    repeat (40) @(negedge mclk);
    $display("test reset done");
    foreach (rows[r])
    begin
      u_mst.start();
      put(8'h82, 1'b1);
      put(rows[r][15:8], 1'b1);
      put(rows[r][7:0], 1'b1);
      u_mst.stop();
      ref_mem[rows[r][15:8]] = rows[r][7:0];
      u_mst.start();
      put(8'h82, 1'b1);
      put(rows[r][15:8], 1'b1);
      u_mst.start();
      put(8'h83, 1'b1);
      get(ref_mem[rows[r][15:8]], 1'b1);
      u_mst.stop();
    end
    $display("test rows done");
    u_mst.start();
    put(8'hA4, 1'b0);
    put(8'h00, 1'b0);
    u_mst.stop();
    check8("ptr kept", rd_addr, 8'hC8);
    u_mst.start();
    put(8'h83, 1'b1);
    get(ref_mem[8'hC8], 1'b1);
    u_mst.stop();
    $display("test foreign address done");
    u_mst.start();
    put(8'h82, 1'b1);
    put(8'hFE, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      put(8'(8'h11 * (k + 1)), 1'b1);
      ref_mem[8'(8'hFE + k)] = 8'(8'h11 * (k + 1));
    end
    u_mst.stop();
    u_mst.start();
    put(8'h82, 1'b1);
    put(8'hFE, 1'b1);
    u_mst.start();
    put(8'h83, 1'b1);
    for (int k = 0; k < 4; k++)
      get(ref_mem[8'(8'hFE + k)], k == 3);
    #40 check1("released", sda_oe, 1'b0);
    u_mst.stop();
    u_mst.start();
    put(8'h83, 1'b1);
    get(ref_mem[8'h02], 1'b1);
    u_mst.stop();
    $display("test wrap done");
    @(negedge mclk) wr_ready = 1'b0;
    u_mst.start();
    put(8'h82, 1'b1);
    put(8'h40, 1'b1);
    put(8'h44, 1'b1);
    put(8'h45, 1'b1);
    put(8'h46, 1'b0);
    u_mst.stop();
    check1("buffer held", wr_valid, 1'b1);
    @(negedge mclk) wr_ready = 1'b1;
    repeat (4) @(negedge mclk);
    check1("buffer empty", wr_valid, 1'b0);
    check8("mem 40", mem[8'h40], 8'h44);
    check8("mem 41", mem[8'h41], 8'h45);
    check8("mem 42", mem[8'h42], ref_mem[8'h42]);
    check8("ptr after refusal", rd_addr, 8'h43);
    $display("test stall done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
